// file: rtl/dac_ctl_pkg.sv
/*
 * Constants for the serial-command DAC control block.
 * Assumes a single system clock; the serial link is sampled, not clocked on.
 */
package dac_ctl_pkg;
    localparam int CODE_W    = 12;
    localparam int WORD_W    = 16;
    localparam int CMD_W     = 3;
    localparam int CMD_MSB   = 15;
    localparam int CODE_MSB  = 12;
    localparam int CODE_LSB  = 1;
    localparam int SUB_POS   = 0;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID  = 12'h800;
    typedef enum logic [2:0] {
        CMD_NOP       = 3'h0,
        CMD_LOAD_IN   = 3'h1,
        CMD_LOAD_ALL  = 3'h2,
        CMD_UPDATE    = 3'h3,
        CMD_USER_LOW  = 3'h4,
        CMD_SHUTDOWN  = 3'h5,
        CMD_USER_HIGH = 3'h6,
        CMD_DOUT_EDG  = 3'h7
    } cmd_t;
endpackage

// file: rtl/dac_serial_command_control.sv
/*
 * Serial command decoder, double-buffered code registers, shutdown control.
 * Assumes mclk runs much faster than the serial clock; all pins except mclk and srst are async.
 */
// Function
// - A word is 16 bits MSB first: command, twelve code bits, zero sub-bit.
// - Data is shifted in on serial clock rising edges while select is low.
// - Select rising edge decodes the command and transfers data.
// - Command 000 does nothing; 001 loads the input register only.
// - Command 010 loads input and DAC registers and leaves shutdown.
// - Command 011 copies input register to DAC register and leaves shutdown.
// - Command 101 enters shutdown only when lockout input is high.
// - Command 100 drives user output low, 110 drives it high.
// - Command 111 selects output edge: first code bit 1 rising, 00 falling.
// - Shutdown keeps interface alive and preserves the registers.
// - Lockout low forbids entering shutdown by any means.
// - Lockout falling edge wakes the device without serial clock.
// - Shutdown pin high enters shutdown; returning low does not leave it.
// - Shift register leaves on serial out, lag 16 or 15.5 cycles.
// - Clear low resets DAC to the reset value and ends shutdown.
// - Reset-value select high gives midscale, low gives code zero.
`timescale 1ns/100ps
module dac_serial_command_control (
    input  wire logic                              mclk,
    input  wire logic                              srst,
    input  wire logic                              cs_n,
    input  wire logic                              sclk,
    input  wire logic                              din,
    input  wire logic                              shutdown_lockout_n,
    input  wire logic                              shutdown_pin,
    input  wire logic                              clear_n,
    input  wire logic                              reset_value_select,
    output logic                                   dout,
    output logic                                   user_output,
    output logic [dac_ctl_pkg::CODE_W-1:0]         dac_code,
    output logic [dac_ctl_pkg::CODE_W-1:0]         input_code,
    output logic                                   shutdown,
    output logic                                   dout_mode
);
    import dac_ctl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Only stage 1 feeds logic; stage 0 may still be settling
    logic [1:0] cs_s, sck_s, din_s, lock_s, sdp_s, clear_s, rv_s;
    logic       cs_d, sck_d, lock_d;

    always_ff @(posedge mclk) begin
        cs_s    <= {cs_s[0], cs_n};
        sck_s   <= {sck_s[0], sclk};
        din_s   <= {din_s[0], din};
        lock_s  <= {lock_s[0], shutdown_lockout_n};
        sdp_s   <= {sdp_s[0], shutdown_pin};
        clear_s <= {clear_s[0], clear_n};
        rv_s    <= {rv_s[0], reset_value_select};
        cs_d    <= cs_s[1];
        sck_d   <= sck_s[1];
        lock_d  <= lock_s[1];
    end

    logic sck_rise, sck_fall, cs_rise, lock_fall;
    assign sck_rise  = sck_s[1] & ~sck_d;
    assign sck_fall  = ~sck_s[1] & sck_d;
    assign cs_rise   = cs_s[1] & ~cs_d;
    assign lock_fall = ~lock_s[1] & lock_d;

    // ------------------------------------------------------------
    // Shift register and serial out
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_r <= '0;
        end else if (sck_rise && !cs_s[1]) begin
            shift_r <= {shift_r[WORD_W-2:0], din_s[1]};
        end
    end

    // Mode 0 updates on falling edge (lag 16), Mode 1 on rising (lag 15.5)
    always_ff @(posedge mclk) begin
        if (srst) begin
            dout <= 1'b0;
        end else if ((dout_mode && sck_rise) || (!dout_mode && sck_fall)) begin
            dout <= dout_mode ? shift_r[WORD_W-2] : shift_r[WORD_W-1];
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    cmd_t              cmd;
    logic [CODE_W-1:0] code_f, rst_code;
    assign cmd      = cmd_t'(shift_r[CMD_MSB -: CMD_W]);
    assign code_f   = shift_r[CODE_MSB:CODE_LSB];
    assign rst_code = rv_s[1] ? CODE_MID : CODE_ZERO;

    // Catches reset value at release, not under reset
    logic init_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            input_code <= '0;
            dac_code   <= '0;
        end else if (init_r || !clear_s[1]) begin
            input_code <= rst_code;
            dac_code   <= rst_code;
        end else if (cs_rise) begin
            case (cmd)
                CMD_LOAD_IN:  input_code <= code_f;
                CMD_LOAD_ALL: begin
                    input_code <= code_f;
                    dac_code   <= code_f;
                end
                CMD_UPDATE:   dac_code <= input_code;
                default:      ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            user_output <= 1'b0;
            dout_mode   <= 1'b0;
        end else if (cs_rise) begin
            if (cmd == CMD_USER_LOW) begin
                user_output <= 1'b0;
            end else if (cmd == CMD_USER_HIGH) begin
                user_output <= 1'b1;
            end else if (cmd == CMD_DOUT_EDG) begin
                if (code_f[CODE_W-1]) begin
                    dout_mode <= 1'b1;
                end else if (!code_f[CODE_W-2]) begin
                    dout_mode <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Shutdown; registers are untouched by it
    // ------------------------------------------------------------
    logic sd_req, wake;
    assign sd_req = sdp_s[1] || (cs_rise && cmd == CMD_SHUTDOWN);
    assign wake   = lock_fall || !clear_s[1] ||
                    (cs_rise && (cmd == CMD_LOAD_ALL || cmd == CMD_UPDATE));

    // Wake beats a request in one cycle; after a command wake a pin still high re-enters next cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            shutdown <= 1'b0;
        end else if (!lock_s[1]) begin
            shutdown <= 1'b0;
        end else if (wake) begin
            shutdown <= 1'b0;
        end else if (sd_req) begin
            shutdown <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_load_all;
        cs_rise && cmd == CMD_LOAD_ALL && clear_s[1] && !init_r;
    endsequence

    a_lockout_blocks: assert property (@(posedge mclk) disable iff (srst)
        !lock_s[1] |=> !shutdown) else $error("shutdown while locked out");
    a_load_all_both: assert property (@(posedge mclk) disable iff (srst)
        s_load_all |=> dac_code == $past(code_f) && input_code == $past(code_f))
        else $error("load all failed");
    a_load_in_only: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_LOAD_IN && clear_s[1] && !init_r
        |=> $stable(dac_code) && input_code == $past(code_f))
        else $error("dac changed on input load");
    a_update_copy: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_UPDATE && clear_s[1] && !init_r
        |=> dac_code == $past(input_code) && !shutdown) else $error("update failed");
    a_pin_enters_sd: assert property (@(posedge mclk) disable iff (srst)
        sdp_s[1] && lock_s[1] && !wake |=> shutdown) else $error("pin no shutdown");
    a_shutdown_holds: assert property (@(posedge mclk) disable iff (srst)
        shutdown && lock_s[1] && clear_s[1] && !cs_rise |=> shutdown)
        else $error("shutdown left without wake");
    a_sw_sd_cmd: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_SHUTDOWN && lock_s[1] && clear_s[1] |=> shutdown)
        else $error("command no shutdown");
    a_clear_value: assert property (@(posedge mclk) disable iff (srst)
        !clear_s[1] |=> dac_code == $past(rst_code) && !shutdown)
        else $error("clear failed");
    a_init_value: assert property (@(posedge mclk) disable iff (srst)
        init_r && !cs_rise |=> dac_code == $past(rst_code) &&
        input_code == $past(rst_code) && !user_output && !dout_mode)
        else $error("power-up state wrong");
    a_user_high: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_USER_HIGH |=> user_output) else $error("user output high");
    a_user_low: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_USER_LOW |=> !user_output) else $error("user output low");
    a_mode_one_sel: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_DOUT_EDG && code_f[CODE_W-1] |=> dout_mode)
        else $error("rising-edge mode not set");
    a_mode_zero_sel: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_DOUT_EDG && code_f[CODE_W-1 -: 2] == 2'h0 |=> !dout_mode)
        else $error("falling-edge mode not set");
    a_dout_fall_edge: assert property (@(posedge mclk) disable iff (srst)
        !dout_mode && sck_fall |=> dout == $past(shift_r[WORD_W-1]))
        else $error("serial out wrong in falling mode");
    a_dout_rise_edge: assert property (@(posedge mclk) disable iff (srst)
        dout_mode && sck_rise && !cs_s[1] |=> dout == shift_r[WORD_W-1])
        else $error("serial out wrong in rising mode");
    a_dout_holds: assert property (@(posedge mclk) disable iff (srst)
        !sck_rise && !sck_fall |=> $stable(dout)) else $error("serial out moved");
    a_shift_in: assert property (@(posedge mclk) disable iff (srst)
        sck_rise && !cs_s[1] |=> shift_r[0] == $past(din_s[1]))
        else $error("shift failed");
    a_nop_hold: assert property (@(posedge mclk) disable iff (srst)
        cs_rise && cmd == CMD_NOP && clear_s[1] && !init_r
        |=> $stable(dac_code) && $stable(input_code)) else $error("nop changed");
endmodule

// file: verif/dac_host_model.sv
/*
 * Host-side serial master model: drives select, serial clock and data.
 * Assumes a 400 ns serial clock period and a listener that samples din on rise.
 */
`timescale 1ns/100ps
module dac_host_model (
    output logic        cs_n,
    output logic        sclk,
    output logic        din,
    input  wire logic   dout
);
    logic [15:0] rx;
    logic [15:0] rx_f;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b1;
        rx   = 16'h0000;
        rx_f = 16'h0000;
    end

    // -----------------------------------------------------------------
    // One word, two back-to-back bytes, select low throughout
    // -----------------------------------------------------------------
    task automatic send(input logic [15:0] w);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = w[i];
            #200;
            rx   = {rx[14:0], dout};
            sclk = 1'b1;
            #200;
            rx_f = {rx_f[14:0], dout};
            sclk = 1'b0;
        end
        din = ~w[0];
        #200;
        cs_n = 1'b1;
        #600;
    endtask
endmodule

// file: verif/dac_serial_command_control_tb.sv
/*
 * Self-checking bench for the serial-command DAC control block.
 * Assumes the host model in dac_host_model.sv and the package dac_ctl_pkg.
 */
`timescale 1ns/100ps
module dac_serial_command_control_tb;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        lock_n = 1'b1;
    logic        pin = 1'b0;
    logic        clear_n = 1'b1;
    logic        rsv = 1'b1;
    wire         cs_n, sclk, din, dout, user_output, shutdown, dout_mode;
    wire [11:0]  dac_code, input_code;
    wire [26:0]  obs = {input_code, dac_code, user_output, dout_mode, shutdown};
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [15:0] prev_w = 16'h0000;
    logic        mode_now = 1'b0;
    // Rows: command, code, then expected {input, dac, user, mode, shutdown}
    logic [41:0] rows [12] = '{
        {3'h1, 12'h5a3, 12'h5a3, 12'h800, 3'b000}, {3'h0, 12'hfff, 12'h5a3, 12'h800, 3'b000},
        {3'h5, 12'h000, 12'h5a3, 12'h800, 3'b001}, {3'h1, 12'h123, 12'h123, 12'h800, 3'b001},
        {3'h3, 12'h000, 12'h123, 12'h123, 3'b000}, {3'h6, 12'h000, 12'h123, 12'h123, 3'b100},
        {3'h7, 12'h800, 12'h123, 12'h123, 3'b110}, {3'h7, 12'h400, 12'h123, 12'h123, 3'b110},
        {3'h7, 12'h000, 12'h123, 12'h123, 3'b100}, {3'h5, 12'h000, 12'h123, 12'h123, 3'b101},
        {3'h2, 12'h0f0, 12'h0f0, 12'h0f0, 3'b100}, {3'h4, 12'h000, 12'h0f0, 12'h0f0, 3'b000}};

    dac_serial_command_control dut (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
        .din(din), .shutdown_lockout_n(lock_n), .shutdown_pin(pin), .clear_n(clear_n),
        .reset_value_select(rsv), .dout(dout), .user_output(user_output),
        .dac_code(dac_code), .input_code(input_code), .shutdown(shutdown),
        .dout_mode(dout_mode));
    dac_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

    initial forever #25 mclk = ~mclk;

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test;
        end
    end

    initial begin
        wt(6);
        srst = 1'b0;
        wt(6);
        check(obs, {12'h800, 12'h800, 3'b000});
        for (int i = 0; i < 12; i++) begin
            host.send({rows[i][41:27], 1'b0});
            check(obs, rows[i][26:0]);
            // Before each rise the old word shows in either mode
            check(host.rx, prev_w);
            // Before each fall, rising-edge mode runs half a clock ahead
            check(host.rx_f, mode_now ? {prev_w[14:0], rows[i][41]} : prev_w);
            prev_w   = {rows[i][41:27], 1'b0};
            mode_now = rows[i][1];
        end
        // -------------------------------------------------------------
        // Lockout, pin and clear cases
        // -------------------------------------------------------------
        lock_n = 1'b0;
        host.send(16'ha000);
        check(shutdown, 1'b0);
        pin = 1'b1;
        wt(8);
        check(shutdown, 1'b0);
        lock_n = 1'b1;
        wt(8);
        check(shutdown, 1'b1);
        pin = 1'b0;
        wt(8);
        check(shutdown, 1'b1);
        host.send({3'h1, 12'h777, 1'b0});
        check(input_code, 12'h777);
        check(dac_code, 12'h0f0);
        lock_n = 1'b0;
        wt(8);
        check(obs, {12'h777, 12'h0f0, 3'b000});
        // External-reference settling before the output is relied on
        wt(400);
        lock_n = 1'b1;
        host.send(16'ha000);
        check(shutdown, 1'b1);
        rsv = 1'b0;
        wt(4);
        clear_n = 1'b0;
        wt(8);
        check(obs, 27'h0);
        clear_n = 1'b1;
        wt(8);
        // -------------------------------------------------------------
        // Reset in mid-run after user output high and rising-edge mode
        // -------------------------------------------------------------
        host.send({3'h6, 12'h000, 1'b0});
        host.send({3'h7, 12'h800, 1'b0});
        check(obs[2:1], 2'b11);
        rsv = 1'b1;
        srst = 1'b1;
        wt(6);
        srst = 1'b0;
        wt(2);
        check(obs, {12'h800, 12'h800, 3'b000});
        stop_test;
    end
endmodule
